//--- pkg/rsvs_if.sv
// internal carrier between the sequencer, bus clock generator and flag latch
// assumes all parties run on clk_sys
interface rsvs_if;
   logic                           e_level;
   logic                           e_tick;
   logic                           stop;
   logic                           stretch;
   logic [rsvs_pkg::STRETCH_W-1:0] stretch_len;
   logic                           wd_set;
   logic                           cm_set;
   logic                           flag_clear;
   logic                           wd_flag;
   logic                           cm_flag;

   modport seq (input e_level, e_tick, wd_flag, cm_flag,
                output stop, stretch, stretch_len, wd_set, cm_set, flag_clear);
   modport eck (input stop, stretch, stretch_len, output e_level, e_tick);
   modport lat (input wd_set, cm_set, flag_clear, output wd_flag, cm_flag);
endinterface

//--- pkg/rsvs_pkg.sv
// constants, codes and types of the reset sequencer with start vector select
// assumes clk_sys is the oscillator clock and the bus clock runs at half its rate
// Function
// - bus clock output runs at half the oscillator rate right after reset.
// - single-chip user mode keeps bus clock off; software may enable it.
// - single-chip special mode starts bus clock on; software may disable it.
// - special peripheral mode leaves bus clock pin undriven as an input.
// - stop state halts all clocks, bus clock output included.
// - bus clock cycles may be stretched for slow external accesses.
// - reset is entered from any source at once, left on a clock edge; here entry also waits for the next clk_sys edge.
// - power-on, enabled watchdog, enabled clock monitor, or pin low drive pin low.
// - power-on or clock monitor reset first holds pin low 4096 oscillator cycles.
// - recovery then holds pin low 16 to 17 bus cycles, then releases.
// - pin low nine cycles after release means external; clear flags, vector FFFE.
// - pin high with clock monitor flag set selects vector FFFC.
// - pin high, no monitor flag, watchdog flag set selects vector FFFA.
// - pin high with neither flag selects normal vector FFFE.
// - mode pins set mode during reset; afterwards may track the instruction queue.
// - pull-downs on both mode pins while reset is active.
// - after reset the special mode pin serves background debug or high tag.
package rsvs_pkg;
   localparam int          STARTUP_CYC = 4096;
   localparam int          LOWDRV_ECYC = 16;
   localparam int          SAMPLE_ECYC = 9;
   localparam int          CNT_W       = 13;
   localparam int          STRETCH_W   = 2;
   localparam logic [15:0] VEC_NORMAL  = 16'hFFFE;
   localparam logic [15:0] VEC_CLKMON  = 16'hFFFC;
   localparam logic [15:0] VEC_WDOG    = 16'hFFFA;
   // mode code is {special_mode_pin_n, mode_pin_b, mode_pin_a}
   localparam logic [2:0]  MODE_SPC_SINGLE = 3'h0;
   localparam logic [2:0]  MODE_SPC_PERIPH = 3'h2;
   localparam logic [2:0]  MODE_USR_SINGLE = 3'h4;
   localparam logic [1:0]  CAUSE_NORMAL = 2'h0;
   localparam logic [1:0]  CAUSE_EXT    = 2'h1;
   localparam logic [1:0]  CAUSE_CLKMON = 2'h2;
   localparam logic [1:0]  CAUSE_WDOG   = 2'h3;

   typedef enum logic [2:0]
   {
      RSVS_RUN     = 3'b000,
      RSVS_STARTUP = 3'b001,
      RSVS_LOWDRV  = 3'b010,
      RSVS_RISE    = 3'b011,
      RSVS_WAITHI  = 3'b100
   } rsvs_state_t;
endpackage

//--- verification/rsvs_board_model.sv
// board side of the reset wire: pull-up, push button, slow rise
// assumes the device only ever pulls the wire low
module rsvs_board_model
(
   input  wire logic       clk_sys,
   input  wire logic       dev_pull_low,
   input  wire logic       button_low,
   input  wire logic [4:0] rise_cyc,
   output logic            reset_wire
);
   logic [4:0] since_free = 5'h0;
   always_ff @(posedge clk_sys)
      if (dev_pull_low || button_low)
         since_free <= 5'h0;
      else if (since_free != 5'h1F)
         since_free <= since_free + 5'h1;
   // pull-up lifts the wire rise_cyc clk_sys cycles after the last pull low
   assign reset_wire = !dev_pull_low && !button_low && (since_free >= rise_cyc);
endmodule

//--- verification/rsvs_reset_seq_tb.sv
// self-checking bench: reset sources, vector choice, mode capture, bus clock
// assumes rsvs_board_model on the reset wire and a shortened start-up count
module rsvs_reset_seq_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys, rst, watchdog_enable, watchdog_timeout, clkmon_enable, clkmon_fail;
   logic        reset_pin_in, reset_pin_out, reset_pin_oe, cpu_reset, vector_valid;
   logic [15:0] vector_addr;
   logic [1:0]  reset_cause, stretch_len;
   logic [2:0]  op_mode, mode_lvl;
   logic        stop_mode, bus_clk_sw_wr, bus_clk_sw_val, slow_stretch_en, slow_access;
   logic        e_bus_clock_out, e_bus_clock_oe, mode_pin_a_in, mode_pin_b_in;
   logic        special_mode_pin_n_in, mode_pin_a_out, mode_pin_a_oe, mode_pin_a_pd;
   logic        mode_pin_b_out, mode_pin_b_oe, mode_pin_b_pd, queue_track_en;
   logic        queue_track_0, queue_track_1, debug_select, background_debug_pin;
   logic        high_tag_input, button_low, prev_valid;
   logic [4:0]  rise_cyc;
   logic [17:0] exp_q[$];
   int          seed, mismatches, num_checks;

   rsvs_reset_seq #(.STARTUP_CYC(8)) uut (.clk_sys, .rst, .watchdog_enable,
      .watchdog_timeout, .clkmon_enable, .clkmon_fail, .reset_pin_in, .reset_pin_out,
      .reset_pin_oe, .cpu_reset, .vector_addr, .vector_valid, .reset_cause, .op_mode,
      .stop_mode, .bus_clk_sw_wr, .bus_clk_sw_val, .slow_stretch_en, .slow_access, .stretch_len,
      .e_bus_clock_out, .e_bus_clock_oe, .mode_pin_a_in, .mode_pin_b_in,
      .special_mode_pin_n_in, .mode_pin_a_out, .mode_pin_a_oe, .mode_pin_a_pd,
      .mode_pin_b_out, .mode_pin_b_oe, .mode_pin_b_pd, .queue_track_en, .queue_track_0,
      .queue_track_1, .debug_select, .background_debug_pin, .high_tag_input);
   rsvs_board_model board (.clk_sys, .dev_pull_low(reset_pin_oe), .button_low, .rise_cyc,
      .reset_wire(reset_pin_in));
   // mode pins: device drive wins, else the bench level
   assign mode_pin_a_in = mode_pin_a_oe ? mode_pin_a_out : mode_lvl[0];
   assign mode_pin_b_in = mode_pin_b_oe ? mode_pin_b_out : mode_lvl[1];
   assign special_mode_pin_n_in = mode_lvl[2];

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [17:0] seen, input logic [17:0] want);
      num_checks++;
      if (seen !== want)
      begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // kind: 0 power-on, 1 watchdog, 2 monitor, 3 button, 4 both, 5 button plus watchdog
   task automatic run_seq(input logic [2:0] mode, input int kind, input logic [17:0] want);
      int   n;
      logic on;
      @(negedge clk_sys);
      mode_lvl = mode;
      queue_track_en = 1'b0;
      rise_cyc = 5'($random(seed)) & 5'h0F;
      exp_q.push_back(want);
      rst = (kind == 0);
      watchdog_timeout = (kind == 1 || kind == 4);
      clkmon_fail = (kind == 2 || kind == 4);
      button_low = (kind == 3 || kind == 5);
      @(negedge clk_sys);
      watchdog_timeout = 1'b0;
      clkmon_fail = 1'b0;
      check({15'h0, cpu_reset, mode_pin_a_pd, mode_pin_a_oe}, 18'h6);
      repeat (15) @(negedge clk_sys);
      rst = 1'b0;
      watchdog_timeout = (kind == 5);
      @(negedge clk_sys);
      watchdog_timeout = 1'b0;
      if (kind >= 3)
         repeat (70) @(negedge clk_sys);
      button_low = 1'b0;
      n = 0;
      while (vector_valid !== 1'b1 && n < 300)
      begin
         @(negedge clk_sys);
         n++;
      end
      check({17'h0, vector_valid}, 18'h1);
      on = !(mode == rsvs_pkg::MODE_USR_SINGLE || mode == rsvs_pkg::MODE_SPC_PERIPH);
      repeat (2) @(negedge clk_sys);
      check({17'h0, e_bus_clock_oe}, {17'h0, on});
      if (mode != rsvs_pkg::MODE_SPC_PERIPH)
      begin
         bus_clk_sw_wr = 1'b1;
         bus_clk_sw_val = !on;
         @(negedge clk_sys);
         bus_clk_sw_wr = 1'b0;
         @(negedge clk_sys);
         check({17'h0, e_bus_clock_oe}, {17'h0, !on});
      end
      queue_track_en = 1'b1;
      {mode_lvl[2], queue_track_1, queue_track_0, debug_select} = 4'($random(seed));
      repeat (2) @(negedge clk_sys);
      check({9'h0, op_mode, mode_pin_a_oe, mode_pin_a_out, mode_pin_b_oe, mode_pin_b_out,
         background_debug_pin, high_tag_input}, {9'h0, mode, 1'b1, queue_track_0, 1'b1,
         queue_track_1, debug_select ? mode_lvl[2] : 1'b1,
         debug_select ? 1'b1 : mode_lvl[2]});
   endtask

   task automatic stretch_test();
      int n;
      stop_mode = 1'b1;
      repeat (6) @(negedge clk_sys);
      stop_mode = 1'b0;
      stretch_len = 2'($random(seed));
      {slow_stretch_en, slow_access} = 2'h3;
      repeat (2) @(posedge e_bus_clock_out);
      // count falling clk edges inside the stretched high phase
      @(negedge clk_sys);
      n = 0;
      while (e_bus_clock_out === 1'b1 && n < 9)
      begin
         n++;
         @(negedge clk_sys);
      end
      check(18'(n), 18'(stretch_len) + 18'h1);
      {slow_stretch_en, slow_access} = 2'h0;
   endtask

   always @(negedge clk_sys)
   begin
      if (vector_valid === 1'b1 && prev_valid !== 1'b1)
         check({vector_addr, reset_cause},
            exp_q.size() > 0 ? exp_q.pop_front() : 18'h3FFFF);
      prev_valid = vector_valid;
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      conclude();
   end

   initial
   begin
      seed = 32'h1185AE0F;
      {rst, watchdog_enable, clkmon_enable} = 3'h7;
      {watchdog_timeout, clkmon_fail, stop_mode, bus_clk_sw_wr, bus_clk_sw_val} = 5'h0;
      {slow_stretch_en, slow_access, stretch_len, queue_track_en, queue_track_0} = 6'h0;
      {queue_track_1, debug_select, button_low, prev_valid} = 4'h0;
      mode_lvl = rsvs_pkg::MODE_USR_SINGLE;
      rise_cyc = 5'h0;
      mismatches = 0;
      num_checks = 0;
      run_seq(rsvs_pkg::MODE_USR_SINGLE, 0, {rsvs_pkg::VEC_NORMAL, rsvs_pkg::CAUSE_NORMAL});
      stretch_test();
      run_seq(rsvs_pkg::MODE_SPC_SINGLE, 1, {rsvs_pkg::VEC_WDOG, rsvs_pkg::CAUSE_WDOG});
      run_seq(rsvs_pkg::MODE_SPC_PERIPH, 2, {rsvs_pkg::VEC_CLKMON, rsvs_pkg::CAUSE_CLKMON});
      run_seq(3'h7, 3, {rsvs_pkg::VEC_NORMAL, rsvs_pkg::CAUSE_EXT});
      run_seq(3'h5, 4, {rsvs_pkg::VEC_CLKMON, rsvs_pkg::CAUSE_CLKMON});
      run_seq(3'h1, 1, {rsvs_pkg::VEC_WDOG, rsvs_pkg::CAUSE_WDOG});
      run_seq(rsvs_pkg::MODE_USR_SINGLE, 5, {rsvs_pkg::VEC_NORMAL, rsvs_pkg::CAUSE_EXT});
      {watchdog_enable, clkmon_enable} = 2'h0;
      {watchdog_timeout, clkmon_fail} = 2'h3;
      repeat (3) @(negedge clk_sys);
      {watchdog_timeout, clkmon_fail} = 2'h0;
      check({17'h0, cpu_reset}, 18'h0);
      {watchdog_enable, clkmon_enable} = 2'h3;
      run_seq(rsvs_pkg::MODE_SPC_SINGLE, 0, {rsvs_pkg::VEC_NORMAL, rsvs_pkg::CAUSE_NORMAL});
      conclude();
   end
endmodule

//--- verification/rsvs_seq_props.sv
// checker on the reset sequencer pins, bound to every rsvs_reset_seq
// assumes one clock domain and a synchronous active-high rst
module rsvs_seq_props
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        watchdog_enable,
   input wire logic        watchdog_timeout,
   input wire logic        clkmon_enable,
   input wire logic        clkmon_fail,
   input wire logic        reset_pin_out,
   input wire logic        reset_pin_oe,
   input wire logic        cpu_reset,
   input wire logic [15:0] vector_addr,
   input wire logic        vector_valid,
   input wire logic [1:0]  reset_cause,
   input wire logic [2:0]  op_mode,
   input wire logic        stop_mode,
   input wire logic        slow_stretch_en,
   input wire logic        e_bus_clock_out,
   input wire logic        e_bus_clock_oe,
   input wire logic        mode_pin_a_pd,
   input wire logic        mode_pin_b_pd
);
   logic [2:0] quiet;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // clk_sys cycles of free-running bus clock since stop, stretch or reset, saturating at 7
   always_ff @(posedge clk_sys)
      if (rst || stop_mode || slow_stretch_en || cpu_reset)
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;
   a_wdog_entry:
   assert property (!cpu_reset && watchdog_enable && watchdog_timeout |=>
      (cpu_reset && reset_pin_oe) [*8] ##1 (cpu_reset && reset_pin_oe) [*8] ##1
      (cpu_reset && reset_pin_oe) [*8] ##1 (cpu_reset && reset_pin_oe) [*6])
      else $error("watchdog reset drive too short");
   a_clkmon_startup:
   assert property (!cpu_reset && clkmon_enable && clkmon_fail |=>
      reset_pin_oe [*8] ##1 reset_pin_oe [*8] ##1 reset_pin_oe [*8] ##1
      reset_pin_oe [*8] ##1 reset_pin_oe [*7])
      else $error("clock monitor reset drive too short");
   a_sample_wait:
   assert property ($fell(reset_pin_oe) |-> cpu_reset [*8] ##1 cpu_reset [*8])
      else $error("released before the sampling delay");
   a_vector_cause:
   assert property ($rose(vector_valid) |-> vector_addr ==
      (reset_cause == rsvs_pkg::CAUSE_WDOG ? rsvs_pkg::VEC_WDOG :
      (reset_cause == rsvs_pkg::CAUSE_CLKMON ? rsvs_pkg::VEC_CLKMON : rsvs_pkg::VEC_NORMAL)))
      else $error("vector does not match cause");
   a_valid_out:
   assert property (vector_valid |-> !cpu_reset && !reset_pin_oe)
      else $error("vector valid while in reset");
   a_mode_pulldown:
   assert property (cpu_reset |-> mode_pin_a_pd && mode_pin_b_pd)
      else $error("mode pulldowns off in reset");
   a_open_drain:
   assert property (reset_pin_out == 1'b0)
      else $error("reset pin driven high");
   a_periph_input:
   assert property (!cpu_reset && op_mode == rsvs_pkg::MODE_SPC_PERIPH |-> !e_bus_clock_oe)
      else $error("bus clock driven in peripheral mode");
   a_half_rate:
   assert property (quiet == 3'h7 |-> e_bus_clock_out != $past(e_bus_clock_out))
      else $error("bus clock not at half rate");
   a_stop_freeze:
   assert property (!cpu_reset && stop_mode && $past(stop_mode) && $past(stop_mode, 2)
      |-> $stable(e_bus_clock_out))
      else $error("bus clock moved in stop");
endmodule

bind rsvs_reset_seq rsvs_seq_props u_props (.clk_sys, .rst, .watchdog_enable,
   .watchdog_timeout, .clkmon_enable, .clkmon_fail, .reset_pin_out, .reset_pin_oe,
   .cpu_reset, .vector_addr, .vector_valid, .reset_cause, .op_mode, .stop_mode,
   .slow_stretch_en, .e_bus_clock_out, .e_bus_clock_oe, .mode_pin_a_pd, .mode_pin_b_pd);

//--- verilog/rsvs_e_bus_clock_out_gen.sv
// bus clock generator: clk_sys divided by two, high phase stretchable
// assumes stop and stretch requests are synchronous to clk_sys
module rsvs_e_bus_clock_out_gen
(
   input wire logic clk_sys,
   input wire logic rst,
   rsvs_if.eck      bus
);
   typedef struct packed
   {
      logic                           level;
      logic                           tick;
      logic [rsvs_pkg::STRETCH_W-1:0] hold;
   } rsvs_eck_t;

   rsvs_eck_t s;
   rsvs_eck_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      if (bus.stop)
      begin
         next_s.hold = s.hold;
      end
      else if (s.hold != '0)
      begin
         next_s.hold = s.hold - 1'b1;
      end
      else
      begin
         next_s.level = ~s.level;
         if (s.level)
            next_s.tick = 1'b1;
         else if (bus.stretch)
            next_s.hold = bus.stretch_len;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign bus.e_level = s.level;
   assign bus.e_tick  = s.tick;
endmodule

//--- verilog/rsvs_flag_latch.sv
// latched watchdog and clock monitor failure flags
// assumes set and clear are one-cycle pulses on clk_sys
module rsvs_flag_latch
(
   input wire logic clk_sys,
   input wire logic rst,
   rsvs_if.lat      bus
);
   typedef struct packed
   {
      logic wd;
      logic cm;
   } rsvs_flags_t;

   rsvs_flags_t s;
   rsvs_flags_t next_s;

   always_comb
   begin
      next_s = s;
      if (bus.flag_clear)
         next_s = '0;
      if (bus.wd_set)
         next_s.wd = 1'b1;
      if (bus.cm_set)
         next_s.cm = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign bus.wd_flag = s.wd;
   assign bus.cm_flag = s.cm;
endmodule

//--- verilog/rsvs_reset_seq.sv
// reset sequencer: source capture, timed pin drive, sampling, vector select,
// mode pin capture and bus clock pin control
// assumes clk_sys is the oscillator clock; pins are synchronous to it
module rsvs_reset_seq
#(
   parameter int STARTUP_CYC = rsvs_pkg::STARTUP_CYC,
   parameter int LOWDRV_ECYC = rsvs_pkg::LOWDRV_ECYC,
   parameter int SAMPLE_ECYC = rsvs_pkg::SAMPLE_ECYC
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        watchdog_enable,
   input  wire logic        watchdog_timeout,
   input  wire logic        clkmon_enable,
   input  wire logic        clkmon_fail,
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   output logic             cpu_reset,
   output logic [15:0]      vector_addr,
   output logic             vector_valid,
   output logic [1:0]       reset_cause,
   output logic [2:0]       op_mode,
   input  wire logic        stop_mode,
   input  wire logic        bus_clk_sw_wr,
   input  wire logic        bus_clk_sw_val,
   input  wire logic        slow_stretch_en,
   input  wire logic        slow_access,
   input  wire logic [1:0]  stretch_len,
   output logic             e_bus_clock_out,
   output logic             e_bus_clock_oe,
   input  wire logic        mode_pin_a_in,
   input  wire logic        mode_pin_b_in,
   input  wire logic        special_mode_pin_n_in,
   output logic             mode_pin_a_out,
   output logic             mode_pin_a_oe,
   output logic             mode_pin_a_pd,
   output logic             mode_pin_b_out,
   output logic             mode_pin_b_oe,
   output logic             mode_pin_b_pd,
   input  wire logic        queue_track_en,
   input  wire logic        queue_track_0,
   input  wire logic        queue_track_1,
   input  wire logic        debug_select,
   output logic             background_debug_pin,
   output logic             high_tag_input
);
   localparam int CW = rsvs_pkg::CNT_W;
   localparam logic [CW-1:0] STARTUP_LAST = CW'(STARTUP_CYC - 1);
   localparam logic [CW-1:0] LOWDRV_LAST  = CW'(LOWDRV_ECYC - 1);
   localparam logic [CW-1:0] SAMPLE_LAST  = CW'(SAMPLE_ECYC - 1);

   typedef struct packed
   {
      rsvs_pkg::rsvs_state_t state;
      logic [CW-1:0]         cnt;
      logic                  in_reset;
      logic                  pin_oe;
      logic                  pin_out;
      logic                  clear;
      logic [15:0]           vec;
      logic                  vec_valid;
      logic [1:0]            cause;
      logic [2:0]            mode;
      logic                  e_en;
      logic                  e_out;
      logic                  e_oe;
      logic                  a_out;
      logic                  a_oe;
      logic                  a_pd;
      logic                  b_out;
      logic                  b_oe;
      logic                  b_pd;
      logic                  dbg;
      logic                  tag_hi;
   } rsvs_seq_t;

   // power-on: start-up delay, pin low, pull-downs on, bus clock running
   localparam rsvs_seq_t RST_ST = '{
      state:     rsvs_pkg::RSVS_STARTUP,
      cnt:       '0,
      in_reset:  1'b1,
      pin_oe:    1'b1,
      pin_out:   1'b0,
      clear:     1'b0,
      vec:       rsvs_pkg::VEC_NORMAL,
      vec_valid: 1'b0,
      cause:     rsvs_pkg::CAUSE_NORMAL,
      mode:      rsvs_pkg::MODE_SPC_SINGLE,
      e_en:      1'b1,
      e_out:     1'b0,
      e_oe:      1'b0,
      a_out:     1'b0,
      a_oe:      1'b0,
      a_pd:      1'b1,
      b_out:     1'b0,
      b_oe:      1'b0,
      b_pd:      1'b1,
      dbg:       1'b1,
      tag_hi:    1'b1
   };

   rsvs_if ifc ();

   rsvs_seq_t s;
   rsvs_seq_t next_s;

   logic wd_evt;
   logic cm_evt;

   // vector choice when the pin has risen; monitor beats watchdog
   function automatic logic [17:0] rsvs_pick(input logic cm, input logic wd);
      logic [17:0] r;
      if (cm)
         r = {rsvs_pkg::CAUSE_CLKMON, rsvs_pkg::VEC_CLKMON};
      else if (wd)
         r = {rsvs_pkg::CAUSE_WDOG, rsvs_pkg::VEC_WDOG};
      else
         r = {rsvs_pkg::CAUSE_NORMAL, rsvs_pkg::VEC_NORMAL};
      return r;
   endfunction

   assign wd_evt = watchdog_timeout & watchdog_enable;
   assign cm_evt = clkmon_fail & clkmon_enable;

   assign ifc.wd_set      = wd_evt;
   assign ifc.cm_set      = cm_evt;
   assign ifc.flag_clear  = s.clear;
   assign ifc.stop        = stop_mode;
   assign ifc.stretch     = slow_stretch_en & slow_access & ~s.in_reset;
   assign ifc.stretch_len = stretch_len;

   rsvs_e_bus_clock_out_gen u_bus_clk
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .bus     (ifc.eck)
   );

   rsvs_flag_latch u_flags
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .bus     (ifc.lat)
   );

   always_comb
   begin
      logic        release_now;
      logic [17:0] pick;
      release_now = 1'b0;
      pick = rsvs_pick(ifc.cm_flag, ifc.wd_flag);
      next_s = s;
      next_s.clear = 1'b0;
      next_s.pin_out = 1'b0;
      case (s.state)
         rsvs_pkg::RSVS_RUN:
         begin
            if (cm_evt)
            begin
               next_s.state = rsvs_pkg::RSVS_STARTUP;
               next_s.cnt = '0;
               next_s.pin_oe = 1'b1;
               next_s.in_reset = 1'b1;
               next_s.vec_valid = 1'b0;
            end
            else if (wd_evt || !reset_pin_in)
            begin
               next_s.state = rsvs_pkg::RSVS_LOWDRV;
               next_s.cnt = '0;
               next_s.pin_oe = 1'b1;
               next_s.in_reset = 1'b1;
               next_s.vec_valid = 1'b0;
            end
         end
         rsvs_pkg::RSVS_STARTUP:
         begin
            if (s.cnt == STARTUP_LAST)
            begin
               next_s.state = rsvs_pkg::RSVS_LOWDRV;
               next_s.cnt = '0;
            end
            else
            begin
               next_s.cnt = s.cnt + 1'b1;
            end
         end
         rsvs_pkg::RSVS_LOWDRV:
         begin
            if (ifc.e_tick)
            begin
               if (s.cnt == LOWDRV_LAST)
               begin
                  next_s.state = rsvs_pkg::RSVS_RISE;
                  next_s.cnt = '0;
                  next_s.pin_oe = 1'b0;
               end
               else
               begin
                  next_s.cnt = s.cnt + 1'b1;
               end
            end
         end
         rsvs_pkg::RSVS_RISE:
         begin
            if (ifc.e_tick)
            begin
               if (s.cnt == SAMPLE_LAST)
               begin
                  next_s.clear = 1'b1;
                  next_s.cnt = '0;
                  if (!reset_pin_in)
                  begin
                     next_s.vec = rsvs_pkg::VEC_NORMAL;
                     next_s.cause = rsvs_pkg::CAUSE_EXT;
                     next_s.state = rsvs_pkg::RSVS_WAITHI;
                  end
                  else
                  begin
                     next_s.vec = pick[15:0];
                     next_s.cause = pick[17:16];
                     release_now = 1'b1;
                  end
               end
               else
               begin
                  next_s.cnt = s.cnt + 1'b1;
               end
            end
         end
         rsvs_pkg::RSVS_WAITHI:
         begin
            if (reset_pin_in)
               release_now = 1'b1;
         end
         default:
         begin
            next_s = RST_ST;
         end
      endcase

      // leave reset on this clock edge only
      if (release_now)
      begin
         next_s.state = rsvs_pkg::RSVS_RUN;
         next_s.in_reset = 1'b0;
         next_s.vec_valid = 1'b1;
         next_s.e_en = (s.mode != rsvs_pkg::MODE_USR_SINGLE);
      end

      // mode pins are followed while in reset, frozen at release
      if (s.in_reset)
         next_s.mode = {special_mode_pin_n_in, mode_pin_b_in, mode_pin_a_in};

      // software bus clock switch once out of reset
      if (!s.in_reset && bus_clk_sw_wr)
         next_s.e_en = bus_clk_sw_val;

      next_s.e_out = ifc.e_level;
      next_s.e_oe = next_s.e_en && (next_s.mode != rsvs_pkg::MODE_SPC_PERIPH);

      next_s.a_pd = next_s.in_reset;
      next_s.b_pd = next_s.in_reset;
      next_s.a_oe = !next_s.in_reset && queue_track_en;
      next_s.b_oe = !next_s.in_reset && queue_track_en;
      next_s.a_out = queue_track_0;
      next_s.b_out = queue_track_1;

      // special mode pin routed after reset, held high while in reset
      next_s.dbg = s.in_reset || !debug_select || special_mode_pin_n_in;
      next_s.tag_hi = s.in_reset || debug_select || special_mode_pin_n_in;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s <= RST_ST;
      else
         s <= next_s;
   end

   assign reset_pin_out        = s.pin_out;
   assign reset_pin_oe         = s.pin_oe;
   assign cpu_reset            = s.in_reset;
   assign vector_addr          = s.vec;
   assign vector_valid         = s.vec_valid;
   assign reset_cause          = s.cause;
   assign op_mode              = s.mode;
   assign e_bus_clock_out      = s.e_out;
   assign e_bus_clock_oe       = s.e_oe;
   assign mode_pin_a_out       = s.a_out;
   assign mode_pin_a_oe        = s.a_oe;
   assign mode_pin_a_pd        = s.a_pd;
   assign mode_pin_b_out       = s.b_out;
   assign mode_pin_b_oe        = s.b_oe;
   assign mode_pin_b_pd        = s.b_pd;
   assign background_debug_pin = s.dbg;
   assign high_tag_input       = s.tag_hi;
endmodule
